// ### rtl/smi_core.sv
// Store and multiply instruction datapath for an 8-bit processor core.
//
// Summary of operation
// RL1: Store opcode copies accumulator, no flags.
// RL2: Eight-bit file field spans whole bank.
// RL3: a bit zero selects access bank.
// RL4: a bit one uses bank pointer.
// RL5: Extended set, a zero, f<=5Fh indexes.
// RL6: Literal multiply is unsigned accumulator times k.
// RL7: Product high byte, low byte written.
// RL8: Literal multiply leaves accumulator unchanged.
// RL9: File multiply is unsigned accumulator times file.
// RL10: File multiply keeps accumulator and file.
// RL11: Multiplies never touch flags, zero undetected.
// RL12: No flag changes for any operand.
// RL13: One word, one cycle, Q2 read, Q4 write.
module smi_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Instruction issue
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  // Core state
  input wire logic [7:0] i_accum,
  input wire logic [smi_pkg::BANK_W-1:0] i_bank_sel,
  input wire logic i_ext_en,
  input wire logic [smi_pkg::ADDR_W-1:0] i_index_base,
  // Data memory read port
  output logic [smi_pkg::ADDR_W-1:0] o_rd_addr,
  output logic o_rd_en,
  input wire logic [7:0] i_rd_data,
  // Data memory write port
  output logic [smi_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_en,
  // Product pair and status
  output logic [7:0] o_prod_hi,
  output logic [7:0] o_prod_lo,
  output logic o_busy,
  output logic o_done,
  output logic o_flags_we
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  typedef enum logic [1:0] {
    SMI_OP_NONE = 2'd0,
    SMI_OP_STORE = 2'd1,
    SMI_OP_MULL = 2'd2,
    SMI_OP_MULF = 2'd3
  } smi_op_e;

  function automatic smi_op_e smi_decode(input logic [15:0] instr);
    smi_op_e op;
    op = SMI_OP_NONE;
    // RL1 store opcode
    if (instr[15:9] == smi_pkg::OPC_STORE_HI7) begin
      op = SMI_OP_STORE;
    // RL6 literal multiply opcode
    end else if (instr[15:8] == smi_pkg::OPC_MULL_HI8) begin
      op = SMI_OP_MULL;
    // RL9 file multiply opcode
    end else if (instr[15:9] == smi_pkg::OPC_MULF_HI7) begin
      op = SMI_OP_MULF;
    end
    return op;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  smi_pkg::smi_phase_e phase_q, phase_d;
  smi_op_e op_q, op_d;
  logic [7:0] opnd_q, opnd_d;
  logic a_q, a_d;
  logic [7:0] src_q, src_d;
  logic [7:0] acc_q, acc_d;
  logic [15:0] prod_q, prod_d;
  logic [15:0] work_q, work_d;
  logic [smi_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [smi_pkg::ADDR_W-1:0] res_addr;
  logic take;

  // RL2 full bank reach
  smi_addr_res u_addr (
    .i_opnd(opnd_q),
    .i_a_bit(a_q),
    .i_bank_sel(i_bank_sel),
    .i_ext_en(i_ext_en),
    .i_index_base(i_index_base),
    .o_addr(res_addr)
  );

  // Only an idle sequencer accepts work, so an instruction offered while busy is dropped.
  assign take = (phase_q == smi_pkg::SMI_Q1) && i_instr_valid && (smi_decode(i_instr) != SMI_OP_NONE);

  // ----------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------
  // Each instruction holds the datapath for four clocks; the next may start right after Q4.
  always_comb begin
    phase_d = phase_q;
    op_d = op_q;
    // RL13 four quarter cycle
    unique case (phase_q)
      smi_pkg::SMI_Q1: begin
        if (take) begin
          op_d = smi_decode(i_instr);
          phase_d = smi_pkg::SMI_Q2;
        end
      end
      smi_pkg::SMI_Q2: begin
        phase_d = smi_pkg::SMI_Q3;
      end
      smi_pkg::SMI_Q3: begin
        phase_d = smi_pkg::SMI_Q4;
      end
      smi_pkg::SMI_Q4: begin
        op_d = SMI_OP_NONE;
        phase_d = smi_pkg::SMI_Q1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_q <= smi_pkg::SMI_Q1;
      op_q <= SMI_OP_NONE;
    end else begin
      phase_q <= phase_d;
      op_q <= op_d;
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  always_comb begin
    opnd_d = opnd_q;
    a_d = a_q;
    acc_d = acc_q;
    src_d = src_q;
    addr_d = addr_q;
    work_d = work_q;
    if (take) begin
      opnd_d = i_instr[smi_pkg::OPND_MSB:0];
      a_d = i_instr[smi_pkg::A_BIT_POS];
      // The accumulator is latched at issue; a store writes that value even if it moves later.
      acc_d = i_accum;
    end
    if (phase_q == smi_pkg::SMI_Q2) begin
      // RL3 RL4 RL5 resolved address kept
      // Operand capture happens here so a write-back in the same slot cannot race it.
      addr_d = res_addr;
      src_d = (op_q == SMI_OP_MULL) ? opnd_q : i_rd_data;
    end
    if (phase_q == smi_pkg::SMI_Q3) begin
      // RL6 unsigned product
      // The product is formed a quarter early so the Q4 load is a plain register copy.
      work_d = {8'h00, acc_q} * {8'h00, src_q};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      opnd_q <= smi_pkg::DATA_RST;
      a_q <= smi_pkg::A_BIT_RST;
      acc_q <= smi_pkg::DATA_RST;
      src_q <= smi_pkg::DATA_RST;
      addr_q <= '0;
      work_q <= {smi_pkg::PROD_RST, smi_pkg::PROD_RST};
    end else begin
      opnd_q <= opnd_d;
      a_q <= a_d;
      acc_q <= acc_d;
      src_q <= src_d;
      addr_q <= addr_d;
      work_q <= work_d;
    end
  end

  // ----------------------------------------
  // Product pair
  // ----------------------------------------
  // Both bytes load from one register, so a reader never sees a half-updated pair.
  always_comb begin
    prod_d = prod_q;
    // RL7 product pair update
    if ((phase_q == smi_pkg::SMI_Q4) && ((op_q == SMI_OP_MULL) || (op_q == SMI_OP_MULF))) begin
      prod_d = work_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prod_q <= {smi_pkg::PROD_RST, smi_pkg::PROD_RST};
    end else begin
      prod_q <= prod_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rd_addr = res_addr;
  // RL10 file read only
  assign o_rd_en = (phase_q == smi_pkg::SMI_Q2) && (op_q == SMI_OP_MULF);
  assign o_wr_addr = addr_q;
  // RL1 store to file
  assign o_wr_data = acc_q;
  // RL8 accumulator never written
  assign o_wr_en = (phase_q == smi_pkg::SMI_Q4) && (op_q == SMI_OP_STORE);
  assign o_prod_hi = prod_q[15:8];
  assign o_prod_lo = prod_q[7:0];
  assign o_busy = (phase_q != smi_pkg::SMI_Q1);
  assign o_done = (phase_q == smi_pkg::SMI_Q4);
  // RL11 flags untouched
  // RL12 no flag writes
  assign o_flags_we = 1'b0;

endmodule

// ### rtl/smi_pkg.sv
// Package of encodings, field positions and reset values for the store and multiply datapath.
package smi_pkg;

  // ----------------------------------------
  // Opcode fields
  // ----------------------------------------
  localparam logic [6:0] OPC_STORE_HI7 = 7'h37;
  localparam logic [6:0] OPC_MULF_HI7 = 7'h01;
  localparam logic [7:0] OPC_MULL_HI8 = 8'h0D;
  localparam int OPC_MSB = 15;
  localparam int A_BIT_POS = 8;
  localparam int OPND_MSB = 7;

  // ----------------------------------------
  // Addressing constants
  // ----------------------------------------
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;

  // ----------------------------------------
  // Reset values and cycle phases
  // ----------------------------------------
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // The a bit comes out of reset at one, the banked default.
  localparam logic A_BIT_RST = 1'b1;
  localparam logic [1:0] Q_LAST = 2'd3;

  typedef enum logic [1:0] {
    SMI_Q1 = 2'b00,
    SMI_Q2 = 2'b01,
    SMI_Q3 = 2'b11,
    SMI_Q4 = 2'b10
  } smi_phase_e;

endpackage

// ### rtl/smi_addr_res.sv
// File-operand address resolver for the a bit and indexed literal offset mode.
module smi_addr_res (
  // Operand fields
  input wire logic [7:0] i_opnd,
  input wire logic i_a_bit,
  // Core state
  input wire logic [smi_pkg::BANK_W-1:0] i_bank_sel,
  input wire logic i_ext_en,
  input wire logic [smi_pkg::ADDR_W-1:0] i_index_base,
  // Resolved address
  output logic [smi_pkg::ADDR_W-1:0] o_addr
);

  always_comb begin
    if (i_a_bit) begin
      // RL4 banked via pointer
      o_addr = {i_bank_sel, i_opnd};
    end else if (i_ext_en && (i_opnd <= smi_pkg::INDEXED_LIMIT)) begin
      // RL5 indexed literal offset
      o_addr = i_index_base + {4'h0, i_opnd};
    end else if (i_opnd < smi_pkg::ACCESS_SPLIT) begin
      // RL3 access bank low
      o_addr = {smi_pkg::ACCESS_LOW_BANK, i_opnd};
    end else begin
      // RL3 access bank high
      o_addr = {smi_pkg::ACCESS_HIGH_BANK, i_opnd};
    end
  end

endmodule

// ### tb/smi_core_chk.sv
// Port-level checker for the store and multiply datapath.
module smi_core_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Issue side
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_accum,
  input wire logic [smi_pkg::BANK_W-1:0] i_bank_sel,
  // Results
  input wire logic [smi_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic o_rd_en,
  input wire logic [7:0] o_wr_data,
  input wire logic o_wr_en,
  input wire logic [7:0] o_prod_hi,
  input wire logic [7:0] o_prod_lo,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_flags_we
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence take_mull;
    !o_busy && i_instr_valid && i_instr[15:8] == smi_pkg::OPC_MULL_HI8;
  endsequence
  sequence busy_span;
    o_busy [*3] ##1 !o_busy;
  endsequence
  AST_FLAGS: assert property (!o_flags_we)
    else $error("flags written");
  AST_BUSY: assert property ($rose(o_busy) |-> busy_span)
    else $error("busy span wrong");
  AST_DONE: assert property ($rose(o_busy) |-> ##2 o_done ##1 !o_done)
    else $error("done not in last phase");
  AST_WR: assert property (o_wr_en |-> o_done && o_wr_data == $past(i_accum, 3))
    else $error("store data wrong");
  AST_RD: assert property (o_rd_en |-> $rose(o_busy) && $past(i_instr[15:9]) == smi_pkg::OPC_MULF_HI7)
    else $error("file read misplaced");
  AST_BANK: assert property (o_rd_en && $past(i_instr[8]) |-> o_rd_addr == {i_bank_sel, $past(i_instr[7:0])})
    else $error("banked address wrong");
  AST_HOLD: assert property (!o_done |=> $stable({o_prod_hi, o_prod_lo}))
    else $error("product moved");
  AST_PROD: assert property (take_mull |-> ##4 {o_prod_hi, o_prod_lo} == $past(i_accum, 4) * $past(i_instr[7:0], 4))
    else $error("literal product wrong");
endmodule
bind smi_core smi_core_chk smi_core_chk_inst (.*);

// ### tb/tb_top.sv
// Self-checking bench for the store and multiply datapath.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, i_instr_valid = 0, i_ext_en = 0, o_rd_en, o_wr_en, o_busy, o_done, o_flags_we;
  logic [15:0] i_instr = 0;
  logic [7:0] i_accum = 0, i_rd_data = 0, o_wr_data, o_prod_hi, o_prod_lo;
  logic [3:0] i_bank_sel = 0;
  logic [11:0] i_index_base = 0, o_rd_addr, o_wr_addr;
  int num_errors = 0, compares = 0, seed = 8, kd, a, f, ea, acc, prod = 0;
  smi_core smi_core_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_accum(i_accum),
    .i_bank_sel(i_bank_sel),
    .i_ext_en(i_ext_en),
    .i_index_base(i_index_base),
    .o_rd_addr(o_rd_addr),
    .o_rd_en(o_rd_en),
    .i_rd_data(i_rd_data),
    .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data),
    .o_wr_en(o_wr_en),
    .o_prod_hi(o_prod_hi),
    .o_prod_lo(o_prod_lo),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_flags_we(o_flags_we)
  );
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #1 i_sys_rst = 0;
    for (int n = 0; n < 90; n++) begin
      kd = n % 3;
      a = $random(seed) & 1;
      f = (n % 5 == 0) ? 95 : (n % 5 == 1) ? 96 : $random(seed) & 255;
      acc = (n < 3) ? 0 : $random(seed) & 255;
      i_accum = acc[7:0];
      i_ext_en = 1'($random(seed));
      i_bank_sel = 4'($random(seed));
      i_index_base = 12'($random(seed));
      i_rd_data = 8'($random(seed));
      i_instr = kd == 0 ? {smi_pkg::OPC_STORE_HI7, a[0], f[7:0]} : kd == 1 ? {smi_pkg::OPC_MULL_HI8, f[7:0]}
        : {smi_pkg::OPC_MULF_HI7, a[0], f[7:0]};
      i_instr_valid = 1;
      ea = a ? {i_bank_sel, f[7:0]} : (i_ext_en && f < 96) ? i_index_base + f : (f < 96 ? f : 'hF00 + f);
      if (kd > 0) prod = acc * (kd == 1 ? f : i_rd_data);
      @(posedge i_clk);
      // Odd tests offer a literal multiply while busy; the design must drop it.
      #1 i_instr_valid = 1'(n % 2);
      i_instr = {smi_pkg::OPC_MULL_HI8, 8'($random(seed))};
      i_accum = ~i_accum;
      if (kd == 2) chk(16'(o_rd_addr), 16'(ea[11:0]));
      chk(16'(o_rd_en), 16'(kd == 2));
      @(posedge i_clk);
      #1 i_rd_data = ~i_rd_data;
      @(posedge i_clk);
      #1 chk(16'(o_done), 16'h0001);
      chk(16'(o_wr_en), 16'(kd == 0));
      if (kd == 0) chk(16'(o_wr_addr), 16'(ea[11:0]));
      if (kd == 0) chk(16'(o_wr_data), 16'(acc[7:0]));
      chk(16'(o_flags_we), 16'h0000);
      @(posedge i_clk);
      #1 chk({o_prod_hi, o_prod_lo}, prod[15:0]);
      chk(16'(o_busy), 16'h0000);
      $display("test %0d done", n);
    end
    // A reset in mid-instruction abandons it and returns the product pair to its reset value.
    i_accum = 8'h03;
    i_instr = {smi_pkg::OPC_MULL_HI8, 8'h05};
    i_instr_valid = 1;
    @(posedge i_clk);
    #1 i_sys_rst = 1;
    i_instr_valid = 0;
    repeat (2) @(posedge i_clk);
    #1 i_sys_rst = 0;
    chk({o_prod_hi, o_prod_lo}, {smi_pkg::PROD_RST, smi_pkg::PROD_RST});
    chk(16'(o_busy), 16'h0000);
    i_instr_valid = 1;
    @(posedge i_clk);
    #1 i_instr_valid = 0;
    repeat (3) @(posedge i_clk);
    #1 chk({o_prod_hi, o_prod_lo}, 16'h000F);
    $display("test reset done");
    stop_test();
  end
endmodule
